// >>> hdl/bsc_defines.svh
`ifndef BSC_DEFINES_SVH
`define BSC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define BSC_CLK_HZ          40000000
`define BSC_DEBOUNCE_US     5000
`define BSC_DEBOUNCE_CYC    ((`BSC_CLK_HZ / 1000000) * `BSC_DEBOUNCE_US)
`define BSC_POR_US          100
`define BSC_POR_CYC         ((`BSC_CLK_HZ / 1000000) * `BSC_POR_US)
`define BSC_OSC_HZ          20000000
`define BSC_CPU_HZ          5000000
`define BSC_CPU_DIV         (`BSC_OSC_HZ / `BSC_CPU_HZ)
`define BSC_WIN_WCLK_HZ     20000000
`define BSC_FLOP_WCLK_HZ    16000000

// ----------------------------------------------------------------------------
// Register map (byte addresses)
// ----------------------------------------------------------------------------
`define BSC_REG_STRAP       12'h000
`define BSC_REG_CTRL        12'h004
`define BSC_REG_STATUS      12'h008
`define BSC_REG_WAIT        12'h00C

// Strap register fields.
`define BSC_STRAP_W1        0
`define BSC_STRAP_W2        1
`define BSC_STRAP_W4        2
`define BSC_STRAP_ROM       3
`define BSC_STRAP_AUTOBOOT  4
`define BSC_STRAP_UNIT_LO   5
`define BSC_STRAP_UNIT_HI   6
`define BSC_STRAP_RATE      7
`define BSC_STRAP_SERBOOT   8

// Decoded configuration fields and chain state bits in the status register.
`define BSC_STAT_WAITS_LSB  0
`define BSC_STAT_ROM_EN     4
`define BSC_STAT_AUTOBOOT   5
`define BSC_STAT_UNIT_LSB   6
`define BSC_STAT_RATE10     8
`define BSC_STAT_SERBOOT    9
`define BSC_STAT_FAULT      10
`define BSC_STAT_RST_OUT    11
`define BSC_STAT_DBG_OUT    12

// Control register fields.
`define BSC_CTRL_SW_RST     0
`define BSC_CTRL_SW_DBG     1
`define BSC_CTRL_SW_FAULT   2
`define BSC_CTRL_RESET      32'h0000_0000

// Wait-state weights and boot-unit encodings.
`define BSC_W1_WEIGHT       3'h1
`define BSC_W2_WEIGHT       3'h2
`define BSC_W4_WEIGHT       3'h4
`define BSC_UNIT_LO_ADD     2'h1
`define BSC_UNIT_WIN        2'h1
`define BSC_UNIT_FLOP       2'h3

`endif

// >>> hdl/bsc_pkg.sv
package bsc_pkg;

    typedef enum logic [2:0]
    {
        BSC_MEM_IDLE = 3'b001,
        BSC_MEM_WAIT = 3'b010,
        BSC_MEM_DONE = 3'b100
    } bsc_mem_t;

    typedef struct packed
    {
        logic [9:0]  strap_lat;
        logic [1:0]  btn_sync_rst;
        logic [1:0]  btn_sync_dbg;
        logic        btn_rst;
        logic        btn_dbg;
        logic [17:0] cnt_rst;
        logic [17:0] cnt_dbg;
        logic [15:0] por_cnt;
        logic        por_active;
        logic        in_reset;
        logic [2:0]  ctrl;
        logic        cpu_rst;
        logic        cpu_dbg;
        logic        up_fault;
        logic        fault_led;
        logic [1:0]  cpu_div;
        logic        cpu_clk;
        bsc_mem_t    mem_st;
        logic [2:0]  wait_cnt;
        logic        mem_wait;
        logic [31:0] prdata;
        logic        pslverr;
    } bsc_state_t;

endpackage

// >>> hdl/bsc_top.sv
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`include "bsc_defines.svh"

// How it works
// - Up and down ports carry the same reset, debug and fault chain signals.
// - Reset and debug flow down to subordinates; fault flows up to the controller.
// - An asserted chain debug request puts the processor into its snapshot mode.
// - Backplane chain signals are active low and are inverted for the processor.
// - Local reset, debug and fault requests are ORed into the chain signals.
// - The processor fault output also lights a local indicator.
// - Front-panel reset and debug buttons are debounced before use.
// - Every power-up produces a reset pulse.
// - Wait straps add 1, 2 and 4 T-states when off; contributions sum. The code holds wait for that many sys_clk cycles instead.
// - The ROM strap disables on-chip ROM when off, enables it when on.
// - Boot straps are sampled on reset through three port-A lines.
// - The auto-boot strap requests boot from disk when on.
// - Boot unit is winchester 1 or floppy 3, plus one when low strap on. The 2-bit code wraps floppy 3 plus one to 0.
// - The serial rate strap selects 20 Mbit/s off, 10 Mbit/s on.
// - The serial-boot strap selects ROM boot off, link boot on.
// - Boot strap lines idle high and port-A lines drive only after reset.
// - The processor clock is 5 MHz, divided from the 40 MHz system clock.
// - Write timing clock is 20 MHz for winchester, 16 MHz for floppy.
// - External memory cycle is extended while wait is high.
module bsc_top
#(
    parameter int DEBOUNCE_CYC = `BSC_DEBOUNCE_CYC,
    parameter int POR_CYC      = `BSC_POR_CYC
)
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        osc_20m,
    input  wire logic        down_rst_n,
    input  wire logic        down_debug_req_n,
    output logic             down_fault_n,
    output logic             up_rst_n,
    output logic             up_debug_req_n,
    input  wire logic        up_fault_n,
    input  wire logic        btn_rst_n,
    input  wire logic        btn_debug_n,
    input  wire logic        cpu_fault,
    output logic             cpu_rst,
    output logic             cpu_debug,
    output logic             fault_led,
    output logic             cpu_clk_5m,
    input  wire logic        wait_strap_w1,
    input  wire logic        wait_strap_w2,
    input  wire logic        wait_strap_w4,
    input  wire logic        onchip_rom_strap,
    input  wire logic        disk_autoboot_strap,
    input  wire logic        boot_unit_strap_lo,
    input  wire logic        boot_unit_strap_hi,
    input  wire logic        serial_rate_strap,
    input  wire logic        serial_boot_strap,
    input  wire logic        port_a_line4_i,
    input  wire logic        port_a_line6_i,
    input  wire logic        port_a_line5_i,
    input  wire logic [2:0]  port_a_drive,
    output logic [2:0]       port_a_o,
    output logic [2:0]       port_a_oe_n,
    input  wire logic        write_timing_clk_in,
    input  wire logic        mem_cycle_start,
    output logic             mem_wait,
    output logic             rom_enable,
    output logic             autoboot,
    output logic [1:0]       boot_unit,
    output logic             rate_10m,
    output logic             serial_boot,
    output logic             write_clk_out,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr
);
    import bsc_pkg::*;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic logic [2:0] bsc_waits(input logic [2:0] s);
        logic [2:0] w;
        w = 3'h0;
        if (!s[0])
        begin
            w = w + `BSC_W1_WEIGHT;
        end
        if (!s[1])
        begin
            w = w + `BSC_W2_WEIGHT;
        end
        if (!s[2])
        begin
            w = w + `BSC_W4_WEIGHT;
        end
        return w;
    endfunction

    function automatic logic [1:0] bsc_unit(input logic lo, input logic hi);
        logic [1:0] u;
        u = hi ? `BSC_UNIT_FLOP : `BSC_UNIT_WIN;
        if (lo)
        begin
            u = u + `BSC_UNIT_LO_ADD;
        end
        return u;
    endfunction

    function automatic logic [31:0] bsc_status(input bsc_state_t s, input logic [2:0] w);
        logic [31:0] r;
        r = 32'h0000_0000;
        r[`BSC_STAT_WAITS_LSB +: 3] = w;
        r[`BSC_STAT_ROM_EN]         = s.strap_lat[`BSC_STRAP_ROM];
        r[`BSC_STAT_AUTOBOOT]       = s.strap_lat[`BSC_STRAP_AUTOBOOT];
        r[`BSC_STAT_UNIT_LSB +: 2]  = bsc_unit(s.strap_lat[`BSC_STRAP_UNIT_LO],
                                               s.strap_lat[`BSC_STRAP_UNIT_HI]);
        r[`BSC_STAT_RATE10]         = s.strap_lat[`BSC_STRAP_RATE];
        r[`BSC_STAT_SERBOOT]        = s.strap_lat[`BSC_STRAP_SERBOOT];
        r[`BSC_STAT_FAULT]          = s.fault_led;
        r[`BSC_STAT_RST_OUT]        = s.cpu_rst;
        r[`BSC_STAT_DBG_OUT]        = s.cpu_dbg;
        return r;
    endfunction

    // Straps read as on until latched, so a missed latch leaves the ROM enabled.
    function automatic bsc_state_t bsc_reset_state();
        bsc_state_t r;
        r            = '0;
        r.mem_st     = BSC_MEM_IDLE;
        r.por_active = 1'b1;
        r.in_reset   = 1'b1;
        r.cpu_rst    = 1'b1;
        r.strap_lat  = 10'h3FF;
        r.ctrl       = 3'(`BSC_CTRL_RESET);
        return r;
    endfunction

    function automatic logic [17:0] bsc_debounce_step(input logic raw, input logic stable,
                                                      input logic [17:0] cnt);
        if (raw == stable)
        begin
            return 18'h0;
        end
        return cnt + 18'h1;
    endfunction

    bsc_state_t st;
    bsc_state_t next_st;
    logic       apb_wr;
    logic       chain_rst_req;
    logic       chain_dbg_req;
    logic [2:0] waits;

    assign waits   = bsc_waits(st.strap_lat[2:0]);
    assign apb_wr  = psel && penable && pwrite;
    assign chain_rst_req = !down_rst_n || st.btn_rst || st.por_active
                         || st.ctrl[`BSC_CTRL_SW_RST];
    assign chain_dbg_req = !down_debug_req_n || st.btn_dbg
                         || st.ctrl[`BSC_CTRL_SW_DBG];

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        // --------------------------------------------------------------------
        // Buttons
        // --------------------------------------------------------------------
        // Buttons: two-stage sync, then a stable-for-N counter filter.
        next_st.btn_sync_rst = {st.btn_sync_rst[0], !btn_rst_n};
        next_st.btn_sync_dbg = {st.btn_sync_dbg[0], !btn_debug_n};
        next_st.cnt_rst = bsc_debounce_step(st.btn_sync_rst[1], st.btn_rst, st.cnt_rst);
        next_st.cnt_dbg = bsc_debounce_step(st.btn_sync_dbg[1], st.btn_dbg, st.cnt_dbg);
        if (st.cnt_rst >= 18'(DEBOUNCE_CYC - 1))
        begin
            next_st.btn_rst = st.btn_sync_rst[1];
            next_st.cnt_rst = 18'h0;
        end
        if (st.cnt_dbg >= 18'(DEBOUNCE_CYC - 1))
        begin
            next_st.btn_dbg = st.btn_sync_dbg[1];
            next_st.cnt_dbg = 18'h0;
        end
        // Power-on pulse lasts a fixed time after every rstn release.
        if (st.por_active)
        begin
            next_st.por_cnt = st.por_cnt + 16'h1;
            if (st.por_cnt >= 16'(POR_CYC - 1))
            begin
                next_st.por_active = 1'b0;
            end
        end
        // --------------------------------------------------------------------
        // Chain and straps
        // --------------------------------------------------------------------
        next_st.cpu_rst  = chain_rst_req;
        next_st.cpu_dbg  = chain_dbg_req;
        next_st.in_reset = chain_rst_req;
        // Straps are live only while reset is held; frozen afterwards.
        if (st.in_reset)
        begin
            next_st.strap_lat = {1'b0, serial_boot_strap, serial_rate_strap,
                                 boot_unit_strap_hi, boot_unit_strap_lo,
                                 disk_autoboot_strap, onchip_rom_strap,
                                 wait_strap_w4, wait_strap_w2,
                                 wait_strap_w1};
            next_st.strap_lat[`BSC_STRAP_AUTOBOOT] = port_a_line4_i & disk_autoboot_strap;
            next_st.strap_lat[`BSC_STRAP_UNIT_LO]  = port_a_line5_i & boot_unit_strap_lo;
            next_st.strap_lat[`BSC_STRAP_UNIT_HI]  = port_a_line6_i & boot_unit_strap_hi;
        end
        next_st.up_fault  = !up_fault_n;
        next_st.fault_led = cpu_fault || !up_fault_n
                          || st.ctrl[`BSC_CTRL_SW_FAULT];
        // --------------------------------------------------------------------
        // Clocks and memory wait
        // --------------------------------------------------------------------
        // Processor clock comes from sys_clk, since sampling the oscillator would alias.
        next_st.cpu_div = st.cpu_div + 2'h1;
        if (st.cpu_div == 2'(`BSC_CLK_HZ / `BSC_CPU_HZ / 2 - 1))
        begin
            next_st.cpu_div = 2'h0;
            next_st.cpu_clk = !st.cpu_clk;
        end
        // Memory wait generator: hold wait for the summed number of sys_clk cycles.
        case (st.mem_st)
            BSC_MEM_IDLE:
            begin
                next_st.mem_wait = 1'b0;
                if (mem_cycle_start && waits != 3'h0)
                begin
                    next_st.mem_st   = BSC_MEM_WAIT;
                    next_st.mem_wait = 1'b1;
                    next_st.wait_cnt = waits - 3'h1;
                end
            end
            BSC_MEM_WAIT:
            begin
                if (st.wait_cnt == 3'h0)
                begin
                    next_st.mem_st   = BSC_MEM_DONE;
                    next_st.mem_wait = 1'b0;
                end
                else
                begin
                    next_st.wait_cnt = st.wait_cnt - 3'h1;
                end
            end
            BSC_MEM_DONE:
            begin
                if (!mem_cycle_start)
                begin
                    next_st.mem_st = BSC_MEM_IDLE;
                end
            end
            default:
            begin
                next_st.mem_st   = BSC_MEM_IDLE;
                next_st.mem_wait = 1'b0;
            end
        endcase
        // --------------------------------------------------------------------
        // Register bus
        // --------------------------------------------------------------------
        // APB slave: zero wait states.
        next_st.pslverr = 1'b0;
        if (psel && !penable)
        begin
            next_st.prdata = 32'h0000_0000;
            case (paddr)
                `BSC_REG_STRAP:  next_st.prdata = {23'h0, st.strap_lat[8:0]};
                `BSC_REG_CTRL:   next_st.prdata = {29'h0, st.ctrl};
                `BSC_REG_STATUS: next_st.prdata = bsc_status(st, waits);
                `BSC_REG_WAIT:   next_st.prdata = {29'h0, waits};
                default:         next_st.pslverr = 1'b1;
            endcase
        end
        if (apb_wr && paddr == `BSC_REG_CTRL)
        begin
            next_st.ctrl = pwdata[2:0];
        end
    end

    // ------------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (!rstn)
        begin
            st <= bsc_reset_state();
        end
        else
        begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign up_rst_n       = !st.cpu_rst;
    assign up_debug_req_n = !st.cpu_dbg;
    assign down_fault_n   = !st.fault_led;
    assign cpu_rst        = st.cpu_rst;
    assign cpu_debug      = st.cpu_dbg;
    assign fault_led      = st.fault_led;
    assign cpu_clk_5m     = st.cpu_clk;
    assign mem_wait       = st.mem_wait;
    // Port-A lines float (pulled high) while straps are read, so the straps never fight.
    assign port_a_o       = port_a_drive;
    assign port_a_oe_n    = st.in_reset ? 3'h7 : 3'h0;
    assign rom_enable     = st.strap_lat[`BSC_STRAP_ROM];
    assign autoboot       = st.strap_lat[`BSC_STRAP_AUTOBOOT];
    assign boot_unit      = bsc_unit(st.strap_lat[`BSC_STRAP_UNIT_LO],
                                     st.strap_lat[`BSC_STRAP_UNIT_HI]);
    assign rate_10m       = st.strap_lat[`BSC_STRAP_RATE];
    assign serial_boot    = st.strap_lat[`BSC_STRAP_SERBOOT];
    // The external write clock passes straight on; its rate picks precomp timing.
    assign write_clk_out  = write_timing_clk_in;
    assign prdata         = st.prdata;
    assign pready         = 1'b1;
    assign pslverr        = st.pslverr && psel && penable;

endmodule

// >>> verification/bsc_assertions.sv
`timescale 1ns/1ps
module bsc_assertions
(
    input wire logic       sys_clk,
    input wire logic       rstn,
    input wire logic       down_rst_n,
    input wire logic       down_debug_req_n,
    input wire logic       down_fault_n,
    input wire logic       up_rst_n,
    input wire logic       up_debug_req_n,
    input wire logic       up_fault_n,
    input wire logic       cpu_fault,
    input wire logic       cpu_rst,
    input wire logic       cpu_debug,
    input wire logic       fault_led,
    input wire logic       cpu_clk_5m,
    input wire logic [2:0] port_a_drive,
    input wire logic [2:0] port_a_o,
    input wire logic [2:0] port_a_oe_n,
    input wire logic       write_timing_clk_in,
    input wire logic       write_clk_out,
    input wire logic       rom_enable,
    input wire logic [1:0] boot_unit,
    input wire logic       serial_boot
);
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    chk_rst_chain: assert property (!down_rst_n |=> cpu_rst && !up_rst_n)
        else $error("Chain reset not passed on.");
    chk_dbg_chain: assert property (!down_debug_req_n |=> cpu_debug && !up_debug_req_n)
        else $error("Chain debug request not passed on.");
    chk_fault_up: assert property ((!up_fault_n || cpu_fault) |=> !down_fault_n)
        else $error("Fault not passed upward.");
    chk_fault_led: assert property (cpu_fault |=> fault_led)
        else $error("Fault indicator dark.");
    chk_por_pulse: assert property ($rose(rstn) |-> cpu_rst [*8])
        else $error("Power-up reset pulse too short.");
    chk_oe_reset: assert property ($rose(rstn) |-> port_a_oe_n == 3'h7)
        else $error("Port lines driven during reset.");
    chk_port_pass: assert property (port_a_o == port_a_drive)
        else $error("Port data mismatch.");
    chk_wclk_pass: assert property (write_clk_out == write_timing_clk_in)
        else $error("Write clock not passed through.");
    // A toggle every fourth cycle gives 5 MHz from the 40 MHz system clock.
    chk_cpu_clk: assert property ($changed(cpu_clk_5m) |=> $stable(cpu_clk_5m) [*3] ##1 $changed(cpu_clk_5m))
        else $error("Processor clock period wrong.");
    chk_strap_hold: assert property ((!cpu_rst && !$past(cpu_rst) && !$past(cpu_rst, 2)) |-> $stable({rom_enable, boot_unit, serial_boot}))
        else $error("Strap outputs changed in operation.");
endmodule
bind bsc_top bsc_assertions bsc_assertions_i (.*);

// >>> verification/bsc_upstream_model.sv
`timescale 1ns/1ps
module bsc_upstream_model
(
    input  wire logic sys_clk,
    input  wire logic req_rst,
    input  wire logic req_dbg,
    input  wire logic down_fault_n,
    output logic      down_rst_n,
    output logic      down_debug_req_n,
    output logic      fault_seen
);
    // ------------------------------------------------------------------
    // Controller side of the chain
    // ------------------------------------------------------------------
    initial
    begin
        down_rst_n = 1'b1;
        down_debug_req_n = 1'b1;
        fault_seen = 1'b0;
    end
    // The same three signals, active low: reset and debug go down, fault comes up.
    always @(posedge sys_clk)
    begin
        down_rst_n <= ~req_rst;
        down_debug_req_n <= ~req_dbg;
        fault_seen <= ~down_fault_n;
    end
endmodule

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`include "bsc_defines.svh"
module tb_top;
    // ------------------------------------------------------------------
    // Stimulus and wiring
    // ------------------------------------------------------------------
    logic sys_clk = 1'b0, rstn = 1'b0, req_rst = 1'b0, req_dbg = 1'b0, fault_seen;
    logic up_fault_n = 1'b1, btn_rst_n = 1'b1, btn_debug_n = 1'b1, cpu_fault = 1'b0;
    logic wait_strap_w1 = 1'b0, wait_strap_w2 = 1'b0, wait_strap_w4 = 1'b0;
    logic onchip_rom_strap = 1'b0, disk_autoboot_strap = 1'b0, boot_unit_strap_lo = 1'b0;
    logic boot_unit_strap_hi = 1'b0, serial_rate_strap = 1'b0, serial_boot_strap = 1'b0;
    logic [2:0] port_a_drive = 3'h0, port_a_o, port_a_oe_n, pa_lines = 3'h7;
    logic wclk = 1'b0, mem_cycle_start = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [1:0] boot_unit;
    logic down_rst_n, down_debug_req_n, down_fault_n, up_rst_n, up_debug_req_n, cpu_rst;
    logic cpu_debug, fault_led, cpu_clk_5m, mem_wait, rom_enable, autoboot, rate_10m;
    logic serial_boot, write_clk_out, pready, pslverr;
    int n_fail = 0;
    int total_checks = 0;
    bsc_upstream_model bsc_upstream_model_i (.*);
    bsc_top #(.DEBOUNCE_CYC(4), .POR_CYC(8)) bsc_top_i (.osc_20m(1'b0),
        .port_a_line4_i(pa_lines[0]), .port_a_line5_i(pa_lines[1]),
        .port_a_line6_i(pa_lines[2]), .write_timing_clk_in(wclk), .*);
    initial forever #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) wclk <= ~wclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        chk(pready, 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic set_straps(input logic [8:0] s);
        {serial_boot_strap, serial_rate_strap, boot_unit_strap_hi, boot_unit_strap_lo} <= s[8:5];
        {disk_autoboot_strap, onchip_rom_strap, wait_strap_w4, wait_strap_w2, wait_strap_w1} <= s[4:0];
    endtask
    task automatic t_straps(input logic [8:0] s);
        logic [1:0] u;
        u = s[6] ? `BSC_UNIT_FLOP : (`BSC_UNIT_WIN + {1'b0, s[5]});
        set_straps(s);
        rstn <= 1'b0;
        cyc(8);
        rstn <= 1'b1;
        @(negedge sys_clk);
        chk(cpu_rst, 1'b1);
        cyc(14);
        chk({cpu_rst, rom_enable, autoboot, rate_10m, serial_boot}, {1'b0, s[3], s[4], s[7], s[8]});
        chk(boot_unit, u);
        set_straps(~s);
        cyc(4);
        chk({serial_boot, rate_10m, boot_unit, autoboot, rom_enable}, {s[8:7], u, s[4:3]});
        set_straps(s);
    endtask
    task automatic t_memwait(input logic [8:0] s);
        int n;
        int k;
        n = 0;
        mem_cycle_start <= 1'b1;
        for (k = 0; k < 12; k++)
        begin
            @(posedge sys_clk);
            if (mem_wait === 1'b1) n++;
            else if (n > 0 || k > 1) mem_cycle_start <= 1'b0;
        end
        chk(n, (s[0] ? 0 : 1) + (s[1] ? 0 : 2) + (s[2] ? 0 : 4));
    endtask
    task automatic t_regs(input logic [8:0] s);
        logic [31:0] rd;
        logic e;
        apb(1'b1, `BSC_REG_CTRL, 32'h2, rd, e);
        cyc(3);
        chk({cpu_debug, up_debug_req_n}, 2'b10);
        apb(1'b0, `BSC_REG_CTRL, 32'h0, rd, e);
        chk(rd, 32'h2);
        apb(1'b1, `BSC_REG_CTRL, 32'h4, rd, e);
        cyc(3);
        chk(down_fault_n, 1'b0);
        apb(1'b1, `BSC_REG_CTRL, 32'h0, rd, e);
        apb(1'b0, `BSC_REG_STRAP, 32'h0, rd, e);
        chk(rd[8:0], s);
        apb(1'b0, `BSC_REG_STATUS, 32'h0, rd, e);
        chk(rd[`BSC_STAT_ROM_EN], s[3]);
        apb(1'b1, 12'h010, 32'h7, rd, e);
        chk(e, 1'b1);
    endtask
    task automatic t_portlines;
        pa_lines <= 3'h0;
        set_straps(9'h1FF);
        rstn <= 1'b0;
        cyc(8);
        rstn <= 1'b1;
        cyc(20);
        chk({autoboot, boot_unit, rate_10m, serial_boot}, {1'b0, `BSC_UNIT_WIN, 2'b11});
        pa_lines <= 3'h7;
        cyc(2);
    endtask
    task automatic t_chain;
        req_dbg <= 1'b1;
        cyc(4);
        chk({cpu_debug, up_debug_req_n}, 2'b10);
        req_dbg <= 1'b0;
        up_fault_n <= 1'b0;
        cyc(4);
        chk({up_debug_req_n, down_fault_n, fault_seen}, 3'b101);
        up_fault_n <= 1'b1;
        cpu_fault <= 1'b1;
        cyc(4);
        chk({fault_led, down_fault_n}, 2'b10);
        cpu_fault <= 1'b0;
        req_rst <= 1'b1;
        cyc(4);
        chk({cpu_rst, up_rst_n}, 2'b10);
        req_rst <= 1'b0;
        cyc(20);
    endtask
    task automatic t_button;
        btn_debug_n <= 1'b0;
        cyc(1);
        btn_debug_n <= 1'b1;
        cyc(12);
        chk(cpu_debug, 1'b0);
        btn_debug_n <= 1'b0;
        cyc(12);
        chk(cpu_debug, 1'b1);
        btn_debug_n <= 1'b1;
        btn_rst_n <= 1'b0;
        cyc(12);
        chk({cpu_debug, cpu_rst}, 2'b01);
        btn_rst_n <= 1'b1;
        cyc(20);
    endtask
    task automatic tally_and_finish;
        $display("Checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        t_straps(9'h0AA);
        t_memwait(9'h0AA);
        t_regs(9'h0AA);
        port_a_drive <= 3'h5;
        cyc(2);
        chk({port_a_o, port_a_oe_n}, 6'h28);
        t_straps(9'h155);
        t_memwait(9'h155);
        t_portlines();
        t_chain();
        t_button();
        tally_and_finish();
    end
    initial
    begin
        cyc(5000);
        n_fail++;
        tally_and_finish();
    end
endmodule
